// file: spdsel_defines.svh
// constants for the speed reference selector: widths, limits, steps and timing
`ifndef SPDSEL_DEFINES_SVH
`define SPDSEL_DEFINES_SVH

`define SPDSEL_FW           17
`define SPDSEL_SW           19
`define SPDSEL_AIN_W        10
`define SPDSEL_AIN_SHIFT    10
`define SPDSEL_TW           16
`define SPDSEL_NSEG         16
`define SPDSEL_NPRESET      15
`define SPDSEL_LAST_SEG     4'hF
`define SPDSEL_FREQ_MAX     19'h186A0
`define SPDSEL_FREQ_ZERO    17'h00000
`define SPDSEL_STEP_FINE    4'h1
`define SPDSEL_STEP_COARSE  4'hA
`define SPDSEL_MULT_MIN     8'h01
`define SPDSEL_MULT_MAX     8'hFA
`define SPDSEL_RAMP_FIRST   2'h0
`define SPDSEL_CLK_MHZ      100
`define SPDSEL_DEB_TIME_US  20000
`define SPDSEL_TICK_TIME_US 100000
`define SPDSEL_NTERM        7

`endif

// file: spdsel_pkg.sv
// types shared by the speed reference selector
package spdsel_pkg;

   typedef enum logic [2:0]
   {
      SPDSEL_MODE_NORMAL     = 3'h0,
      SPDSEL_MODE_INTERNAL   = 3'h1,
      SPDSEL_MODE_EXT4       = 3'h2,
      SPDSEL_MODE_EXT16      = 3'h3,
      SPDSEL_MODE_EXT4_AUTO  = 3'h4,
      SPDSEL_MODE_EXT16_AUTO = 3'h5
   } spdsel_mode_t;

   typedef enum logic [1:0]
   {
      SPDSEL_SEQ_IDLE = 2'h0,
      SPDSEL_SEQ_RUN  = 2'h1,
      SPDSEL_SEQ_DONE = 2'h2
   } spdsel_seq_t;

endpackage

// file: spdsel_term_sync.sv
// terminal synchroniser and debouncer, one lane per input terminal
`timescale 1ns/1ps
`default_nettype none

module spdsel_term_sync
#(
   parameter int N       = 7,
   parameter int DEB_CYC = 2000000
)
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // raw pins and filtered levels
   input  wire logic [N-1:0] pin_in,
   output logic      [N-1:0] level_out
);

   localparam int CW = $clog2(DEB_CYC + 1);

   for (genvar i = 0; i < N; i++)
   begin : g_lane
      logic          meta_reg;
      logic          sync_reg;
      logic          lvl_reg;
      logic [CW-1:0] cnt_reg;

      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
         end
         else
         begin
            meta_reg <= pin_in[i];
            sync_reg <= meta_reg;
         end
      end

      // level must hold for the full window before it is accepted
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            cnt_reg <= '0;
            lvl_reg <= 1'b0;
         end
         else if (sync_reg == lvl_reg)
            cnt_reg <= '0;
         else if (cnt_reg == CW'(DEB_CYC - 1))
         begin
            cnt_reg <= '0;
            lvl_reg <= sync_reg;
         end
         else
            cnt_reg <= cnt_reg + 1'b1;
      end

      assign level_out[i] = lvl_reg;
   end

endmodule

`default_nettype wire

// file: spdsel_top.sv
// speed reference selector: analog curve, up/down trim and segment speed choice
`timescale 1ns/1ps
`default_nettype none
`include "spdsel_defines.svh"

module spdsel_top
   import spdsel_pkg::*;
#(
   parameter int DEB_CYC  = `SPDSEL_DEB_TIME_US * `SPDSEL_CLK_MHZ,
   parameter int TICK_CYC = `SPDSEL_TICK_TIME_US * `SPDSEL_CLK_MHZ
)
(
   // clock and reset
   input  wire logic                                    clk,
   input  wire logic                                    rst_n,
   // terminals (asynchronous pins)
   input  wire logic                                    segment_select_bit0,
   input  wire logic                                    segment_select_bit1,
   input  wire logic                                    segment_select_bit2,
   input  wire logic                                    segment_select_bit3,
   input  wire logic                                    term_up,
   input  wire logic                                    term_down,
   input  wire logic                                    term_reverse,
   input  wire logic                                    run_cmd,
   // analog front end and external speed reference
   input  wire logic [`SPDSEL_AIN_W-1:0]                analog_in,
   input  wire logic                                    analog_ref_select,
   input  wire logic [`SPDSEL_FW-1:0]                   ext_speed_freq,
   // stored settings
   input  wire logic [`SPDSEL_FW-1:0]                   main_freq,
   input  wire logic [`SPDSEL_FW-1:0]                   analog_high_end_freq,
   input  wire logic [`SPDSEL_FW-1:0]                   analog_low_end_freq,
   input  wire logic                                    high_end_bias_dir,
   input  wire logic                                    low_end_bias_dir,
   input  wire logic                                    negative_bias_reverse_enable,
   input  wire logic                                    updown_memory_select,
   input  wire logic                                    updown_step_unit,
   input  wire logic [7:0]                              updown_step_multiple,
   input  wire logic [2:0]                              segment_mode_select,
   input  wire logic [7:0]                              segment_dir_low_bank,
   input  wire logic [7:0]                              segment_dir_high_bank,
   input  wire logic [15:0]                             segment_ramp_sel_low_bank,
   input  wire logic [15:0]                             segment_ramp_sel_high_bank,
   input  wire logic [`SPDSEL_NPRESET*`SPDSEL_FW-1:0]   preset_freq_table,
   input  wire logic [`SPDSEL_NSEG*`SPDSEL_TW-1:0]      segment_timer_table,
   input  wire logic                                    power_off_retention,
   // trim retention store
   input  wire logic                                    restore_strobe,
   input  wire logic signed [`SPDSEL_SW-1:0]            restore_offset,
   output logic                                         retain_enable,
   output logic signed [`SPDSEL_SW-1:0]                 retained_offset,
   // to ramp generator
   output logic [`SPDSEL_FW-1:0]                        freq_ref_reg,
   output logic                                         dir_rev_reg,
   output logic [1:0]                                   ramp_sel_reg,
   output logic                                         run_active_reg,
   output logic                                         ref_update_reg,
   output logic [3:0]                                   seg_index_reg
);

   // ----------------------------------------
   // terminal conditioning
   // ----------------------------------------
   logic [`SPDSEL_NTERM-1:0] term_lvl;
   logic [`SPDSEL_NTERM-1:0] term_prev_reg;
   logic [3:0]               seg_code;
   logic                     up_pulse;
   logic                     down_pulse;
   logic                     rev_lvl;
   logic                     run_meta_reg;
   logic                     run_sync_reg;
   logic                     run_prev_reg;
   logic                     run_eff;
   spdsel_mode_t             mode;

   spdsel_term_sync #(.N(`SPDSEL_NTERM), .DEB_CYC(DEB_CYC)) u_sync
   (
      .clk       (clk),
      .rst_n     (rst_n),
      .pin_in    ({term_reverse, term_down, term_up, segment_select_bit3,
                   segment_select_bit2, segment_select_bit1, segment_select_bit0}),
      .level_out (term_lvl)
   );

   assign seg_code   = term_lvl[3:0];
   assign up_pulse   = term_lvl[4] & ~term_prev_reg[4];
   assign down_pulse = term_lvl[5] & ~term_prev_reg[5];
   assign rev_lvl    = term_lvl[6];
   assign mode       = spdsel_mode_t'(segment_mode_select);
   // auto modes behave as if run were held
   assign run_eff    = run_sync_reg | (mode == SPDSEL_MODE_EXT4_AUTO)
                       | (mode == SPDSEL_MODE_EXT16_AUTO);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         term_prev_reg <= '0;
         run_meta_reg  <= 1'b0;
         run_sync_reg  <= 1'b0;
         run_prev_reg  <= 1'b0;
      end
      else
      begin
         term_prev_reg <= term_lvl;
         run_meta_reg  <= run_cmd;
         run_sync_reg  <= run_meta_reg;
         run_prev_reg  <= run_eff;
      end
   end

   // ----------------------------------------
   // analog curve
   // ----------------------------------------
   logic signed [`SPDSEL_SW-1:0] lo_s;
   logic signed [`SPDSEL_SW-1:0] hi_s;
   logic signed [`SPDSEL_SW-1:0] span_s;
   logic signed [29:0]           prod_s;
   logic signed [`SPDSEL_SW-1:0] ana_reg;
   logic                         ana_neg;
   logic                         ana_rev;
   logic [`SPDSEL_FW-1:0]        ana_mag;

   assign lo_s    = low_end_bias_dir ? -$signed({2'b00, analog_low_end_freq})
                                     : $signed({2'b00, analog_low_end_freq});
   assign hi_s    = high_end_bias_dir ? -$signed({2'b00, analog_high_end_freq})
                                      : $signed({2'b00, analog_high_end_freq});
   assign span_s  = hi_s - lo_s;
   assign prod_s  = span_s * $signed({1'b0, analog_in});
   assign ana_neg = ana_reg[`SPDSEL_SW-1];
   // a negative bias without reverse enabled pins the reference at zero
   assign ana_rev = ana_neg & negative_bias_reverse_enable;
   assign ana_mag = !ana_neg ? ana_reg[`SPDSEL_FW-1:0]
                  : (ana_rev ? 17'((-ana_reg)) : `SPDSEL_FREQ_ZERO);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ana_reg <= '0;
      else
         ana_reg <= lo_s + prod_s[`SPDSEL_SW-1+`SPDSEL_AIN_SHIFT:`SPDSEL_AIN_SHIFT];
   end

   // ----------------------------------------
   // up/down trim
   // ----------------------------------------
   logic [7:0]                   mult;
   logic [11:0]                  step;
   logic signed [`SPDSEL_SW-1:0] offset_reg;
   logic signed [`SPDSEL_SW-1:0] offset_next;

   assign mult = (updown_step_multiple < `SPDSEL_MULT_MIN) ? `SPDSEL_MULT_MIN
               : (updown_step_multiple > `SPDSEL_MULT_MAX) ? `SPDSEL_MULT_MAX
               : updown_step_multiple;
   assign step = (updown_step_unit ? `SPDSEL_STEP_COARSE : `SPDSEL_STEP_FINE) * mult;
   assign retain_enable   = updown_memory_select & power_off_retention;
   assign retained_offset = offset_reg;

   always_comb
   begin
      offset_next = offset_reg;
      if (up_pulse && !down_pulse)
         offset_next = offset_reg + $signed({7'h00, step});
      else if (down_pulse && !up_pulse)
         offset_next = offset_reg - $signed({7'h00, step});
      if (offset_next > $signed(`SPDSEL_FREQ_MAX))
         offset_next = `SPDSEL_FREQ_MAX;
      else if (offset_next < -$signed(`SPDSEL_FREQ_MAX))
         offset_next = -$signed(`SPDSEL_FREQ_MAX);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         offset_reg <= '0;
      else if (restore_strobe && retain_enable)
         offset_reg <= restore_offset;
      else if (run_prev_reg && !run_eff && !updown_memory_select)
         offset_reg <= '0;
      else
         offset_reg <= offset_next;
   end

   // ----------------------------------------
   // internal segment sequencer
   // ----------------------------------------
   localparam int KW = $clog2(TICK_CYC + 1);
   spdsel_seq_t             seq_reg;
   logic [`SPDSEL_TW-1:0]   seg_left_reg;
   logic [KW-1:0]           tick_reg;
   logic                    internal_run;

   assign internal_run = (mode == SPDSEL_MODE_INTERNAL) && run_eff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seq_reg       <= SPDSEL_SEQ_IDLE;
         seg_index_reg <= 4'h0;
         seg_left_reg  <= '0;
         tick_reg      <= '0;
      end
      else
      begin
         case (seq_reg)
            SPDSEL_SEQ_IDLE:
               if (internal_run)
               begin
                  seq_reg       <= SPDSEL_SEQ_RUN;
                  seg_index_reg <= 4'h0;
                  seg_left_reg  <= segment_timer_table[0 +: `SPDSEL_TW];
                  tick_reg      <= '0;
               end
            SPDSEL_SEQ_RUN:
               if (!internal_run)
                  seq_reg <= SPDSEL_SEQ_IDLE;
               else if (seg_left_reg == '0)
               begin
                  // a zero timer costs one cycle and the segment is skipped
                  if (seg_index_reg == `SPDSEL_LAST_SEG)
                     seq_reg <= SPDSEL_SEQ_DONE;
                  else
                  begin
                     seg_index_reg <= seg_index_reg + 4'h1;
                     seg_left_reg  <= segment_timer_table[(seg_index_reg + 4'h1) * `SPDSEL_TW +: `SPDSEL_TW];
                     tick_reg      <= '0;
                  end
               end
               else if (tick_reg == KW'(TICK_CYC - 1))
               begin
                  tick_reg     <= '0;
                  seg_left_reg <= seg_left_reg - 1'b1;
               end
               else
                  tick_reg <= tick_reg + 1'b1;
            SPDSEL_SEQ_DONE:
               if (!internal_run)
                  seq_reg <= SPDSEL_SEQ_IDLE;
            default:
               seq_reg <= SPDSEL_SEQ_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // reference selection
   // ----------------------------------------
   logic [3:0]                   sel_idx;
   logic [`SPDSEL_FW-1:0]        sel_freq;
   logic                         sel_dir;
   logic [1:0]                   sel_ramp;
   logic signed [`SPDSEL_SW-1:0] trimmed;
   logic [`SPDSEL_FW-1:0]        f_next;
   logic                         d_next;
   logic [1:0]                   r_next;
   logic                         run_next;

   assign sel_idx  = (mode == SPDSEL_MODE_INTERNAL) ? seg_index_reg : seg_code;
   assign sel_freq = (sel_idx == 4'h0) ? main_freq
                   : preset_freq_table[(sel_idx - 4'h1) * `SPDSEL_FW +: `SPDSEL_FW];
   assign sel_dir  = sel_idx[3] ? segment_dir_high_bank[sel_idx[2:0]]
                                : segment_dir_low_bank[sel_idx[2:0]];
   assign sel_ramp = sel_idx[3] ? segment_ramp_sel_high_bank[{sel_idx[2:0], 1'b0} +: 2]
                                : segment_ramp_sel_low_bank[{sel_idx[2:0], 1'b0} +: 2];
   assign trimmed  = $signed({2'b00, analog_ref_select ? ana_mag : main_freq}) + offset_reg;

   always_comb
   begin
      f_next   = `SPDSEL_FREQ_ZERO;
      d_next   = rev_lvl;
      r_next   = `SPDSEL_RAMP_FIRST;
      run_next = run_eff;
      case (mode)
         SPDSEL_MODE_INTERNAL:
         begin
            f_next   = sel_freq;
            d_next   = sel_dir;
            r_next   = sel_ramp;
            run_next = (seq_reg == SPDSEL_SEQ_RUN);
         end
         SPDSEL_MODE_EXT4, SPDSEL_MODE_EXT4_AUTO:
            f_next = ext_speed_freq;
         SPDSEL_MODE_EXT16, SPDSEL_MODE_EXT16_AUTO:
            f_next = sel_freq;
         default:
         begin
            // trim never flips direction, it saturates at zero
            if (trimmed < 0)
               f_next = `SPDSEL_FREQ_ZERO;
            else if (trimmed > $signed(`SPDSEL_FREQ_MAX))
               f_next = 17'(`SPDSEL_FREQ_MAX);
            else
               f_next = trimmed[`SPDSEL_FW-1:0];
            d_next = analog_ref_select ? (ana_rev ^ rev_lvl) : rev_lvl;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         freq_ref_reg   <= `SPDSEL_FREQ_ZERO;
         dir_rev_reg    <= 1'b0;
         ramp_sel_reg   <= `SPDSEL_RAMP_FIRST;
         run_active_reg <= 1'b0;
         ref_update_reg <= 1'b0;
      end
      else
      begin
         freq_ref_reg   <= f_next;
         dir_rev_reg    <= d_next;
         ramp_sel_reg   <= r_next;
         run_active_reg <= run_next;
         ref_update_reg <= (term_lvl[3:0] != term_prev_reg[3:0]);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_stop_nomem;
      run_eff ##1 (!run_eff && !updown_memory_select && !restore_strobe);
   endsequence
   sequence s_stop_mem;
      run_eff ##1 (!run_eff && updown_memory_select && !restore_strobe && !up_pulse && !down_pulse);
   endsequence

   a_stop_discard: assert property (s_stop_nomem |=> offset_reg == 0)
      else $error("trim kept after stop with memory off");
   a_stop_keep: assert property (s_stop_mem |=> $stable(offset_reg))
      else $error("trim lost after stop with memory on");
   a_restore_gate: assert property ((restore_strobe && !retain_enable && !up_pulse && !down_pulse
      && !(run_prev_reg && !run_eff)) |=> $stable(offset_reg))
      else $error("trim restored without retention");
   a_step_up: assert property ((up_pulse && !down_pulse && !restore_strobe && offset_reg <= 19'sh0FFFF
      && !(run_prev_reg && !run_eff)) |=> offset_reg == $past(offset_reg) + $signed({7'h00, $past(step)}))
      else $error("wrong up step");
   a_step_unit: assert property ((updown_step_unit && updown_step_multiple == 8'h01) |-> step == 12'h00A)
      else $error("coarse unit step wrong");
   a_neg_block: assert property ((mode == SPDSEL_MODE_NORMAL && analog_ref_select && ana_neg
      && !negative_bias_reverse_enable && !rev_lvl) |=> !dir_rev_reg)
      else $error("negative bias reversed while disabled");
   a_rev_mirror: assert property ((mode == SPDSEL_MODE_NORMAL && analog_ref_select)
      |=> dir_rev_reg == $past(ana_rev ^ rev_lvl))
      else $error("terminal reverse not mirrored");
   a_auto_run: assert property ((mode == SPDSEL_MODE_EXT16_AUTO || mode == SPDSEL_MODE_EXT4_AUTO)
      |=> run_active_reg)
      else $error("auto mode not running");
   a_code_main: assert property ((mode == SPDSEL_MODE_EXT16 && seg_code == 4'h0)
      |=> freq_ref_reg == $past(main_freq))
      else $error("code zero not main frequency");
   a_seg_skip: assert property ((seq_reg == SPDSEL_SEQ_RUN && internal_run && seg_left_reg == 0
      && seg_index_reg != `SPDSEL_LAST_SEG) |=> seg_index_reg == $past(seg_index_reg) + 4'h1)
      else $error("segment did not advance");
   a_seg_dir: assert property ((mode == SPDSEL_MODE_INTERNAL) |=> dir_rev_reg == $past(sel_dir))
      else $error("internal direction not from bank");
   a_code_update: assert property ($changed(seg_code) |=> ref_update_reg)
      else $error("code change not flagged");

endmodule

`default_nettype wire

// file: spdsel_far_model.sv
// terminal pins and ramp generator model for the selector bench
`timescale 1ns/1ps
`default_nettype none
module spdsel_far_model
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // wanted code and reference strobe
   input  wire logic [3:0] code,
   input  wire logic       upd,
   // segment terminal pins, update count
   output logic      [3:0] pins,
   output var int          n_upd
);
   // terminals carry the four segment select functions
   assign pins = code;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         n_upd <= 0;
      else if (upd)
         n_upd <= n_upd + 1;
endmodule
`default_nettype wire

// file: speed_reference_selector_tb.sv
// self-checking bench for the speed reference selector
`timescale 1ns/1ps
`default_nettype none
`include "spdsel_defines.svh"
module speed_reference_selector_tb;
   logic clk = 0, rst_n = 0, up = 0, rev = 0, run = 0, asel = 0, lbd = 0, nre = 0, mem = 0, unit = 1;
   logic [3:0] code = 0, pins, sidx;
   logic [9:0] ain = 0;
   logic [16:0] ext = 0, mf = 17'h01388, lof = 0, fr;
   logic [7:0] mult = 1, dlo = 0;
   logic [2:0] mode = 0;
   logic [15:0] rlo = 0;
   logic [254:0] pt = 0;
   logic [255:0] tt = {16{16'h0010}};
   logic signed [18:0] ro, roff = 0;
   logic dn = 0, por = 1, rstb = 0;
   logic ren, dr, ra, upd;
   logic [1:0] rs;
   int seed = 89, n_errors = 0, compares = 0, nu, k, m, c;
   always #5 clk = ~clk;
   spdsel_top #(.DEB_CYC(4), .TICK_CYC(8)) spdsel_top_i (.clk(clk), .rst_n(rst_n),
      .segment_select_bit0(pins[0]), .segment_select_bit1(pins[1]), .segment_select_bit2(pins[2]),
      .segment_select_bit3(pins[3]), .term_up(up), .term_down(dn), .term_reverse(rev), .run_cmd(run),
      .analog_in(ain), .analog_ref_select(asel), .ext_speed_freq(ext), .main_freq(mf),
      .analog_high_end_freq(17'h02710), .analog_low_end_freq(lof), .high_end_bias_dir(1'b0),
      .low_end_bias_dir(lbd), .negative_bias_reverse_enable(nre), .updown_memory_select(mem),
      .updown_step_unit(unit), .updown_step_multiple(mult), .segment_mode_select(mode),
      .segment_dir_low_bank(dlo), .segment_dir_high_bank(8'h00), .segment_ramp_sel_low_bank(rlo),
      .segment_ramp_sel_high_bank(16'h0000), .preset_freq_table(pt), .segment_timer_table(tt),
      .power_off_retention(por), .restore_strobe(rstb), .restore_offset(roff),
      .retain_enable(ren), .retained_offset(ro), .freq_ref_reg(fr), .dir_rev_reg(dr),
      .ramp_sel_reg(rs), .run_active_reg(ra), .ref_update_reg(upd), .seg_index_reg(sidx));
   spdsel_far_model spdsel_far_model_i (.clk(clk), .rst_n(rst_n), .code(code), .upd(upd), .pins(pins),
      .n_upd(nu));
   task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
      compares++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      if (n_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // bounded wait for a fresh reference at the ramp model
   task automatic wait_upd(input int b);
      for (int i = 0; i < 40 && nu == b; i++)
         cyc(1);
      if (nu == b)
      begin
         chk("ref_update", 1, 0);
         summarize();
      end
      cyc(2);
   endtask
   // one debounced rising step on the up or the down terminal
   task automatic step_trim(input bit down);
      if (down)
         dn <= 1;
      else
         up <= 1;
      cyc(12);
      up <= 0;
      dn <= 0;
      cyc(12);
   endtask
   // analog reference between two positive end points, floor of the 1/1024 scale
   function automatic int ana_exp(input int lo, input int hi, input int a);
      return lo + (((hi - lo) * a) >>> 10);
   endfunction
   initial
   begin
      cyc(4);
      rst_n <= 1;
      for (k = 0; k < 15; k++)
         pt[k*17 +: 17] <= 17'($random(seed)) & 17'h0FFFF;
      ext <= 17'($random(seed)) & 17'h0FFFF;
      mode <= 3;
      cyc(8);
      // corners 15 and 0 first, then random codes
      for (k = 0; k < 20; k++)
      begin
         c = (k == 0) ? 15 : (k == 1) ? 0 : ($random(seed) & 15);
         c = (c == code) ? c ^ 1 : c;
         m = nu;
         code <= 4'(c);
         wait_upd(m);
         chk("freq_ref", (c == 0) ? mf : pt[(c-1)*17 +: 17], fr);
         chk("run_active", 0, ra);
      end
      // modes 2 to 5: automatic run in modes 4 and 5 only, and the external speed source in modes 2 and 4
      for (k = 2; k < 6; k++)
      begin
         mode <= 3'(k);
         cyc(6);
         chk("run_active", (k > 3), ra);
         if (k % 2 == 0)
            chk("freq_ref", ext, fr);
      end
      mode <= 1;
      rev <= 1;
      dlo <= 8'($random(seed));
      rlo <= 16'($random(seed));
      run <= 1;
      cyc(8);
      chk("freq_ref", mf, fr);
      chk("dir_rev", dlo[0], dr);
      chk("ramp_sel", rlo[1:0], rs);
      for (k = 0; k < 300 && sidx !== 4'h1; k++)
         cyc(1);
      chk("seg_index", 1, sidx);
      if (sidx !== 4'h1)
         summarize();
      cyc(2);
      chk("freq_ref", pt[16:0], fr);
      chk("ramp_sel", rlo[3:2], rs);
      chk("dir_rev", dlo[1], dr);
      // trim in normal mode, coarse then fine step
      m = 1 + ({$random(seed)} % 250);
      {mode, rev, mult} <= {3'h0, 1'b0, 8'(m)};
      run <= 0;
      cyc(8);
      run <= 1;
      cyc(8);
      step_trim(0);
      chk("freq_ref", mf + 10 * m, fr);
      unit <= 0;
      step_trim(0);
      chk("retained", 11 * m, ro);
      chk("retain_en", 0, ren);
      run <= 0;
      cyc(8);
      chk("retained", 0, ro);
      mem <= 1;
      run <= 1;
      cyc(8);
      step_trim(0);
      run <= 0;
      cyc(8);
      run <= 1;
      cyc(8);
      chk("freq_ref", mf + m, fr);
      chk("retain_en", 1, ren);
      // coarse down step drives the trim below zero
      unit <= 1;
      step_trim(1);
      chk("freq_ref", mf - 9 * m, fr);
      chk("retained", 19'(-9 * m), ro);
      // restore refused without power-off retention, taken with it
      roff <= 19'($random(seed) % 1000);
      por <= 0;
      rstb <= 1;
      cyc(1);
      rstb <= 0;
      cyc(2);
      chk("retain_en", 0, ren);
      chk("retained", 19'(-9 * m), ro);
      por <= 1;
      rstb <= 1;
      cyc(1);
      rstb <= 0;
      cyc(2);
      chk("retained", roff, ro);
      chk("freq_ref", mf + roff, fr);
      // analog low end, negative bias
      {mem, run, asel, lof, lbd, nre} <= {1'b0, 1'b0, 1'b1, 17'h01000, 1'b1, 1'b1};
      cyc(8);
      run <= 1;
      cyc(8);
      chk("freq_ref", lof, fr);
      chk("dir_rev", 1, dr);
      rev <= 1;
      cyc(8);
      chk("dir_rev", 0, dr);
      {rev, nre} <= 2'b00;
      cyc(8);
      chk("freq_ref", 0, fr);
      lbd <= 0;
      ain <= 10'($random(seed));
      cyc(8);
      chk("dir_rev", 0, dr);
      chk("freq_ref", ana_exp(lof, 17'h02710, ain), fr);
      summarize();
   end
endmodule
`default_nettype wire
